/* File: core/pss_pkg.sv */
/*
 Package for the preamble-search, signal-strength and crystal register bank:
 register indices, field positions, reset values, timing and carrier structs.
 Assumes a 100 MHz modem clock and 8-bit registers on 32-bit bus words.
*/
package pss_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ANT_CTRL = 8'h51;
  localparam logic [7:0] IDX_SEARCH_CTRL = 8'h56;
  localparam logic [7:0] IDX_STRENGTH = 8'h5b;
  localparam logic [7:0] IDX_CRYSTAL = 8'h6e;
  localparam logic [7:0] IDX_SEARCH_STAT = 8'h70;
  localparam int ADDR_W = 10;
  localparam int IDX_LSB = 2;

  // Search control fields
  localparam int B_MASTER = 0;
  localparam int B_AMP = 1;
  localparam int B_DET = 2;
  localparam int B_LIM = 3;
  localparam int B_VCO = 4;
  localparam logic [7:0] SEARCH_RESET = 8'h1e;
  localparam logic [7:0] SEARCH_MASK = 8'h1f;

  // Antenna control fields
  localparam int B_DIVERSITY = 0;
  localparam logic [7:0] ANT_RESET = 8'h40;

  // Crystal control fields, then the strength reset value
  localparam int XB_LSB = 3;
  localparam int XB_MSB = 5;
  localparam logic [2:0] BYPASS_OFF = 3'h0;
  localparam logic [2:0] BYPASS_ON = 3'h7;
  localparam logic [7:0] XTAL_MASK = 8'h38;
  localparam logic [7:0] XTAL_RESET = 8'h00;
  localparam logic [7:0] STRENGTH_RESET = 8'h00;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int REFRESH_US = 125;
  localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
  localparam int DUTY_HALF_CYC = 16;

  typedef struct packed {
    logic vco;
    logic lim;
    logic det;
    logic amp;
  } pss_elem_t;

  typedef struct packed {
    logic [7:0] search;
    logic [7:0] ant;
    logic [7:0] xtal;
    logic [7:0] strength;
  } pss_regs_t;
endpackage : pss_pkg

/* File: core/pss_regs.sv */
/*
 Register bank for low-power preamble search, signal strength readout and
 crystal bypass, reached as an Avalon-MM slave with waitrequest.
 Assumes the modem supplies a search-in-progress level and a sampled
 signal-strength value, both synchronous to i_mclk.
*/
// The implementer's own choice: the Avalon-MM slave port.
// Operation
// - Search control bit 0 is the master enable of low-power preamble search.
// - Search control bit 4 makes the VCO buffer toggle at 50% during search.
// - Search control bit 3 makes the limiter toggle at 50% during search.
// - Search control bit 2 makes the strength detector toggle at 50%.
// - Search control bit 1 makes the low-noise amplifier toggle at 50%.
// - An 8-bit read-only strength level is refreshed every 125 us.
// - Crystal bits 5:3 reset to 000 and 111 selects an external clock.
// - Antenna control bit 0 enables fast antenna diversity.
`timescale 1ns/1ns
module pss_regs #(
  parameter int REFRESH_CYCLES = pss_pkg::REFRESH_CYC,
  parameter int HALF_PERIOD = pss_pkg::DUTY_HALF_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Avalon-MM slave
  input wire logic [pss_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Modem side
  input wire logic i_search_active,
  input wire logic [7:0] i_strength_sample,
  output pss_pkg::pss_elem_t o_elem_on,
  output logic o_search_mode,
  output logic o_diversity_en,
  output logic o_crystal_bypass
);
  typedef struct packed {
    pss_pkg::pss_regs_t regs;
    logic [31:0] rdata;
    logic ack;
    logic [31:0] refresh_cnt;
    logic [31:0] duty_cnt;
    logic phase;
    pss_pkg::pss_elem_t elem;
    logic mode;
    logic div;
    logic byp;
  } pss_state_t;

  pss_state_t s_q;
  pss_state_t s_d;
  logic [7:0] idx;
  logic gating;

  function automatic logic [7:0] read_mux(input logic [7:0] i,
                                          input pss_pkg::pss_regs_t r,
                                          input logic g);
    case (i)
      pss_pkg::IDX_SEARCH_CTRL: read_mux = r.search;
      pss_pkg::IDX_ANT_CTRL: read_mux = r.ant;
      pss_pkg::IDX_STRENGTH: read_mux = r.strength;
      pss_pkg::IDX_CRYSTAL: read_mux = r.xtal;
      pss_pkg::IDX_SEARCH_STAT: read_mux = {7'h00, g};
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  assign idx = 8'(i_address >> pss_pkg::IDX_LSB);

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    gating = s_q.regs.search[pss_pkg::B_MASTER] & i_search_active;
    // Bus access takes one wait cycle, then completes
    if ((i_read | i_write) & ~s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdata = {24'h000000, read_mux(idx, s_q.regs, gating)};
    end
    // A write lands only at the edge that ends its wait, while the master
    // still holds address and data there
    if (i_write & s_q.ack & i_byteenable[0]) begin
      case (idx)
        pss_pkg::IDX_SEARCH_CTRL:
          s_d.regs.search = i_writedata[7:0] & pss_pkg::SEARCH_MASK;
        pss_pkg::IDX_ANT_CTRL: s_d.regs.ant = i_writedata[7:0];
        pss_pkg::IDX_CRYSTAL:
          s_d.regs.xtal = i_writedata[7:0] & pss_pkg::XTAL_MASK;
        default: ;
      endcase
    end
    // Strength level sampled on a fixed period; writes cannot disturb it
    if (s_q.refresh_cnt >= 32'(REFRESH_CYCLES - 1)) begin
      s_d.refresh_cnt = 32'h0;
      s_d.regs.strength = i_strength_sample;
    end else begin
      s_d.refresh_cnt = s_q.refresh_cnt + 32'h1;
    end
    // Square wave for the duty-cycled elements, halted outside a search
    if (!gating) begin
      s_d.duty_cnt = 32'h0;
      s_d.phase = 1'b1;
    end else if (s_q.duty_cnt >= 32'(HALF_PERIOD - 1)) begin
      s_d.duty_cnt = 32'h0;
      s_d.phase = ~s_q.phase;
    end else begin
      s_d.duty_cnt = s_q.duty_cnt + 32'h1;
    end
    s_d.elem.vco = ~gating | ~s_q.regs.search[pss_pkg::B_VCO]
                   | s_d.phase;
    s_d.elem.lim = ~gating | ~s_q.regs.search[pss_pkg::B_LIM]
                   | s_d.phase;
    s_d.elem.det = ~gating | ~s_q.regs.search[pss_pkg::B_DET]
                   | s_d.phase;
    s_d.elem.amp = ~gating | ~s_q.regs.search[pss_pkg::B_AMP]
                   | s_d.phase;
    s_d.mode = s_d.regs.search[pss_pkg::B_MASTER];
    s_d.div = s_d.regs.ant[pss_pkg::B_DIVERSITY];
    s_d.byp = s_d.regs.xtal[pss_pkg::XB_MSB:pss_pkg::XB_LSB]
              == pss_pkg::BYPASS_ON;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
      s_q.regs.search <= pss_pkg::SEARCH_RESET;
      s_q.regs.ant <= pss_pkg::ANT_RESET;
      s_q.regs.xtal <= pss_pkg::XTAL_RESET;
      s_q.regs.strength <= pss_pkg::STRENGTH_RESET;
      s_q.phase <= 1'b1;
      s_q.elem <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_readdata = s_q.rdata;
  assign o_waitrequest = ~s_q.ack;
  assign o_elem_on = s_q.elem;
  assign o_search_mode = s_q.mode;
  assign o_diversity_en = s_q.div;
  assign o_crystal_bypass = s_q.byp;

  sequence seq_gate_off;
    !(s_q.regs.search[pss_pkg::B_MASTER] && i_search_active);
  endsequence

  // A write whose wait has just ended, so it lands at this edge
  sequence seq_write_done;
    !o_waitrequest && i_write && i_byteenable[0];
  endsequence

  // Last count of a duty half period while gating runs
  sequence seq_duty_edge;
    gating && s_q.duty_cnt == 32'(HALF_PERIOD - 1);
  endsequence

  a_idle_elems_on: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    seq_gate_off |=> o_elem_on == 4'hf)
    else $error("element cycled outside a search");
  a_master_mode: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    o_search_mode == s_q.regs.search[pss_pkg::B_MASTER])
    else $error("search mode does not follow master enable");
  a_vco_held: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    !s_q.regs.search[pss_pkg::B_VCO] |=> o_elem_on.vco)
    else $error("vco buffer gated while its cycle enable is clear");
  a_lim_held: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    !s_q.regs.search[pss_pkg::B_LIM] |=> o_elem_on.lim)
    else $error("limiter gated while its cycle enable is clear");
  a_det_held: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    !s_q.regs.search[pss_pkg::B_DET] |=> o_elem_on.det)
    else $error("detector gated while its cycle enable is clear");
  a_amp_phase: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    (gating && s_q.regs.search[pss_pkg::B_AMP] && $past(gating))
    |=> o_elem_on.amp == s_q.phase)
    else $error("amplifier does not follow duty phase");
  // Duty counter and phase together give the 50% square wave
  a_duty_bound: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    s_q.duty_cnt < 32'(HALF_PERIOD))
    else $error("duty counter ran past its half period");
  a_phase_toggle: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    seq_duty_edge |=> s_q.phase != $past(s_q.phase))
    else $error("duty phase did not toggle at half period");
  a_phase_hold: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    gating && s_q.duty_cnt != 32'(HALF_PERIOD - 1)
    |=> $stable(s_q.phase))
    else $error("duty phase toggled early");
  a_strength_hold: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    (s_q.refresh_cnt != 32'(REFRESH_CYCLES - 1))
    |=> $stable(s_q.regs.strength))
    else $error("strength changed between refreshes");
  a_strength_load: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    (s_q.refresh_cnt == 32'(REFRESH_CYCLES - 1))
    |=> s_q.regs.strength == $past(i_strength_sample))
    else $error("strength not loaded at refresh");
  a_refresh_bound: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    s_q.refresh_cnt < 32'(REFRESH_CYCLES))
    else $error("refresh counter ran past its period");
  a_bypass_code: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    o_crystal_bypass ==
    (s_q.regs.xtal[pss_pkg::XB_MSB:pss_pkg::XB_LSB] == pss_pkg::BYPASS_ON))
    else $error("bypass output does not match selector");
  a_crystal_write: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    seq_write_done ##0 (idx == pss_pkg::IDX_CRYSTAL) |=>
    s_q.regs.xtal == ($past(i_writedata[7:0]) & pss_pkg::XTAL_MASK))
    else $error("crystal control write did not land");
  a_search_write: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    seq_write_done ##0 (idx == pss_pkg::IDX_SEARCH_CTRL) |=>
    s_q.regs.search == ($past(i_writedata[7:0]) & pss_pkg::SEARCH_MASK))
    else $error("search control write did not land");
  a_diversity_bit: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    o_diversity_en == s_q.regs.ant[pss_pkg::B_DIVERSITY])
    else $error("diversity output does not match register");
  a_bus_ack: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("bus request not answered in one cycle");
  a_bus_release: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    !o_waitrequest |=> o_waitrequest)
    else $error("waitrequest stayed low for more than one cycle");
  a_read_upper: assert property (@(posedge i_mclk)
    disable iff (i_reset)
    !o_waitrequest |-> o_readdata[31:8] == 24'h000000)
    else $error("read data upper lanes not zero");
endmodule : pss_regs

/* File: test/tb_pss_regs.sv */
/*
 Self-checking bench for pss_regs: Avalon-MM register accesses, duty gating
 windows and strength refresh. Assumes the design package pss_pkg.
*/
`timescale 1ns/1ns
module tb_pss_regs;
  localparam int RC = 20;
  localparam int HP = 4;
  logic i_mclk, i_reset, i_read, i_write, i_search_active;
  logic [9:0] i_address;
  logic [31:0] i_writedata;
  logic [3:0] i_byteenable;
  logic [7:0] i_strength_sample;
  logic [31:0] o_readdata;
  logic o_waitrequest, o_search_mode, o_diversity_en, o_crystal_bypass;
  pss_pkg::pss_elem_t o_elem_on;
  int errors = 0;
  int tests_run = 0;
  logic [7:0] q;
  int low [4];

  pss_regs #(.REFRESH_CYCLES(RC), .HALF_PERIOD(HP)) dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_search_active(i_search_active),
    .i_strength_sample(i_strength_sample), .o_elem_on(o_elem_on),
    .o_search_mode(o_search_mode), .o_diversity_en(o_diversity_en),
    .o_crystal_bypass(o_crystal_bypass));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task end_sim;
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One edge passes first so no strobe is assigned twice in one step
  task bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
    int n;
    @(posedge i_mclk);
    i_address <= {idx, 2'h0};
    i_write <= w;
    i_read <= !w;
    i_writedata <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 20);
    if (o_waitrequest !== 1'b0) begin
      errors++;
      $display("[ERR] waitrequest expected 0 seen %b", o_waitrequest);
      end_sim();
    end
    q = o_readdata[7:0];
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask : bus

  task rd(input logic [7:0] idx, input logic [7:0] exp, input string name);
    bus(idx, 1'b0, 8'h00);
    chk(name, exp, q);
  endtask : rd

  // Any window of two half periods holds exactly HP low cycles
  task gate(input logic [7:0] v, input logic [3:0] on);
    bus(pss_pkg::IDX_SEARCH_CTRL, 1'b1, v);
    repeat (3) @(posedge i_mclk);
    low = '{0, 0, 0, 0};
    repeat (2 * HP) begin
      @(posedge i_mclk);
      for (int b = 0; b < 4; b++) if (o_elem_on[b] !== 1'b1) low[b]++;
    end
    for (int b = 0; b < 4; b++) begin
      chk("elem_low", 8'(on[b] ? HP : 0), 8'(low[b]));
    end
  endtask : gate

  initial begin
    i_reset = 1'b1;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 10'h000;
    i_writedata = 32'h00000000;
    i_byteenable = 4'hf;
    i_search_active = 1'b0;
    i_strength_sample = 8'h00;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    rd(pss_pkg::IDX_SEARCH_CTRL, pss_pkg::SEARCH_RESET, "search");
    rd(pss_pkg::IDX_STRENGTH, pss_pkg::STRENGTH_RESET, "strength");
    rd(pss_pkg::IDX_CRYSTAL, pss_pkg::XTAL_RESET, "xtal");
    rd(pss_pkg::IDX_ANT_CTRL, pss_pkg::ANT_RESET, "ant");
    chk("elem_on", 8'h0f, {4'h0, o_elem_on});
    // Oscillator enable sits outside this block; the bench keeps it at 0
    bus(pss_pkg::IDX_CRYSTAL, 1'b1, 8'hff);
    rd(pss_pkg::IDX_CRYSTAL, pss_pkg::XTAL_MASK, "xtal");
    chk("bypass", 8'h01, {7'h00, o_crystal_bypass});
    bus(pss_pkg::IDX_CRYSTAL, 1'b1, 8'h30);
    rd(pss_pkg::IDX_CRYSTAL, 8'h30, "xtal");
    chk("bypass", 8'h00, {7'h00, o_crystal_bypass});
    // The write lands at the edge that ends the wait; look one edge later
    bus(pss_pkg::IDX_ANT_CTRL, 1'b1, 8'h41);
    @(posedge i_mclk);
    chk("diversity", 8'h01, {7'h00, o_diversity_en});
    // Diversity goes off before any search is enabled
    bus(pss_pkg::IDX_ANT_CTRL, 1'b1, 8'h40);
    @(posedge i_mclk);
    chk("diversity", 8'h00, {7'h00, o_diversity_en});
    // Lane 0 disabled: the write must not reach the register
    i_byteenable <= 4'he;
    bus(pss_pkg::IDX_ANT_CTRL, 1'b1, 8'h41);
    i_byteenable <= 4'hf;
    rd(pss_pkg::IDX_ANT_CTRL, pss_pkg::ANT_RESET, "ant_lane");
    gate(8'h1f, 4'h0);
    chk("search_mode", 8'h01, {7'h00, o_search_mode});
    i_search_active <= 1'b1;
    gate(8'h1e, 4'h0);
    chk("search_mode", 8'h00, {7'h00, o_search_mode});
    gate(8'h1f, 4'hf);
    rd(pss_pkg::IDX_SEARCH_STAT, 8'h01, "gating");
    for (int b = 1; b < 5; b++) begin
      gate(8'h01 | (8'h01 << b), 4'(1 << (b - 1)));
    end
    i_search_active <= 1'b0;
    gate(8'h1f, 4'h0);
    rd(pss_pkg::IDX_SEARCH_STAT, 8'h00, "gating");
    i_strength_sample <= 8'ha5;
    repeat (RC + 3) @(posedge i_mclk);
    rd(pss_pkg::IDX_STRENGTH, 8'ha5, "strength");
    bus(pss_pkg::IDX_STRENGTH, 1'b1, 8'h00);
    rd(pss_pkg::IDX_STRENGTH, 8'ha5, "strength");
    // Reset in mid-run brings bypass and strength back to reset values
    bus(pss_pkg::IDX_CRYSTAL, 1'b1, 8'h38);
    @(posedge i_mclk);
    chk("bypass", 8'h01, {7'h00, o_crystal_bypass});
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    chk("bypass_rst", 8'h00, {7'h00, o_crystal_bypass});
    rd(pss_pkg::IDX_CRYSTAL, pss_pkg::XTAL_RESET, "xtal_rst");
    rd(pss_pkg::IDX_STRENGTH, pss_pkg::STRENGTH_RESET, "strength_rst");
    rd(8'hff, 8'h00, "unmapped");
    end_sim();
  end
endmodule : tb_pss_regs
